// ==== spdr_receiver.sv ====
`timescale 1ns/1ps
// Operation
// R1: out of reset the receiver runs in two-channel mode, no setup write needed.
// R2: control bit 7 set stops clock recovery entirely.
// R3: software routes first, then clears bit 7; acquisition starts once enabled.
// R4: lock sets the lock status bit, pollable by software.
// R5: lock raises a one-cycle lock event toward the audio interrupt latch.
// R6: serial output runs only from lock onward; frame sync here already follows decoded subframes before lock.
// R7: one biphase input; serial clock, frame sync, data and fast clock out.
// R8: recovery adapts to any cell rate within its counter range.
// R9: once locked, drift up to fifteen percent keeps lock.
// R10: non-audio flag follows channel status byte 0 bit 1.
// R11: non-audio flag rise is an interrupt event.
// R12: received validity sets the validity status bit 3.
// R13: four zero words then two sync words set the non-audio flag.
// R14: no sync within 4096 frames clears the non-audio flag.
// R15: burst info and length words after sync are captured.
// R16: sync search continues whatever validity or byte 0 bit 1 say.
// R17: no sync within 4096 frames zeroes the captured words.
// R18: professional mode: bits 2-4 of byte 0 as 110 or 111 mean emphasis.
// R19: consumer mode: bits 3-5 as 100, 010 or 110 mean emphasis.
// R20: emphasis sets the emphasis flag and an interrupt event.
// R21: two control bits select single-channel double-frequency output.
// R22: byte 1 bits 0-3 decode 0111, 1000, 1001 as the three double-frequency kinds.
// R23: status bit 4 reads one while locked.
// R24: error status bits stay set until the status register is read.
module spdr_receiver
    import spdr_pkg::*;
#(
    parameter int IV_W = 8,
    parameter int GOOD_N = GOOD_SUBFRAMES_DEF,
    parameter int BURST_FRAMES = BURST_FRAMES_DEF
) (
    input wire logic clock,
    input wire logic rstn,
    input wire spdr_bus_s bus,
    output logic [31:0] rdata,
    input wire logic biphase_in,
    output spdr_ser_s ser,
    output logic [IRQ_W-1:0] audio_irq_latch
);
    localparam int XW = IV_W + 3;
    localparam int DW = IV_W + 7;

    typedef struct packed {
        logic din;
        logic [IV_W-1:0] iv, unit, lock_unit, ph;
        logic lock;
        logic [2:0] good;
        logic in_pre, pre_first;
        logic [3:0] pre_sum;
        logic chan_b, blk, half, sf_bad;
        logic [27:0] sr;
        logic [4:0] nbit;
        logic [7:0] frame;
        logic [15:0] cs_sh;
        logic [7:0] byte0, byte1;
        spdr_burst_e bst;
        logic [2:0] zc;
        logic [12:0] bcnt;
        logic burst_on;
        logic [15:0] pre_c, pre_d;
        logic nonpcm, emph, valid_st, par_err, bip_err, nostream;
        logic [1:0] single_channel_double_frequency_kind;
        logic pll_dis, single_channel_double_frequency, side;
        logic [31:0] osh;
        logic [31:0] rdata;
        spdr_ser_s ser;
        logic [IRQ_W-1:0] irq;
    } spdr_state_s;

    spdr_state_s s, n;

    logic edge_seen, shorter, stall, drift_bad, got, bitv, bad, done, sf_bad_now, tick;
    logic [XW-1:0] ivx, ux, u3, u5, u7, trk_sum;
    logic [1:0] k;
    logic [DW-1:0] u100, hi, lo;
    logic [27:0] nsr;
    logic [15:0] w16;
    logic [2:0] pro_e, con_e;
    logic [3:0] b1_code;
    logic [31:0] ctrl_word, stat_word;

    always_comb begin
        ctrl_word = '0;
        ctrl_word[CTRL_SINGLE_CHANNEL_DOUBLE_FREQUENCY] = s.single_channel_double_frequency;
        ctrl_word[CTRL_SIDE] = s.side;
        ctrl_word[CTRL_PLL_DIS] = s.pll_dis;
        stat_word = '0;
        stat_word[ST_NONPCM] = s.nonpcm;
        stat_word[ST_EMPH] = s.emph;
        stat_word[ST_NOSTREAM] = s.nostream;
        stat_word[ST_VALID] = s.valid_st;
        stat_word[ST_LOCK] = s.lock; // R23
        stat_word[ST_PARITY] = s.par_err;
        stat_word[ST_BIPHASE] = s.bip_err;
        stat_word[ST_SINGLE_CHANNEL_DOUBLE_FREQUENCY_KIND +: 2] = s.single_channel_double_frequency_kind;
        stat_word[ST_BYTE0 +: 8] = s.byte0;
    end

    always_comb begin
        n = s;
        n.irq = '0;
        n.rdata = '0;
        edge_seen = biphase_in ^ s.din;
        ivx = {2'b00, s.iv, 1'b0};
        ux = {3'b000, s.unit};
        u3 = {2'b00, s.unit, 1'b0} + ux;
        u5 = {1'b0, s.unit, 2'b00} + ux;
        u7 = {s.unit, 3'b000} - ux;
        trk_sum = u3 + {3'b000, s.iv};
        shorter = {1'b0, s.iv, 2'b00} < u3;
        stall = {3'b000, s.iv} > {1'b0, s.unit, 2'b00};
        u100 = DW'(s.unit) * DW'(PCT_BASE);
        hi = DW'(s.lock_unit) * DW'(PCT_BASE + DRIFT_PCT);
        lo = DW'(s.lock_unit) * DW'(PCT_BASE - DRIFT_PCT);
        drift_bad = s.lock && (u100 > hi || u100 < lo);
        got = 1'b0;
        bitv = 1'b0;
        bad = 1'b0;
        done = 1'b0;
        sf_bad_now = 1'b0;
        nsr = s.sr;
        w16 = '0;
        tick = 1'b0;
        pro_e = {s.byte0[2], s.byte0[3], s.byte0[4]};
        con_e = {s.byte0[3], s.byte0[4], s.byte0[5]};
        b1_code = {s.byte1[0], s.byte1[1], s.byte1[2], s.byte1[3]};
        if (ivx < u3) begin
            k = 2'h1;
        end else if (ivx < u5) begin
            k = 2'h2;
        end else if (ivx < u7) begin
            k = 2'h3;
        end else begin
            k = 2'h0;
        end
        n.din = biphase_in;

        // register port: reads clear sticky errors before this cycle's sets
        if (bus.rd) begin
            case (bus.addr)
                OFF_CTRL: n.rdata = ctrl_word;
                OFF_STAT: begin
                    n.rdata = stat_word;
                    n.par_err = 1'b0; // R24
                    n.bip_err = 1'b0;
                    n.nostream = 1'b0;
                    n.valid_st = 1'b0;
                end
                OFF_CHAN: n.rdata = {24'h000000, s.byte1};
                OFF_PRE: n.rdata = {s.pre_d, s.pre_c};
                default: n.rdata = '0;
            endcase
        end
        if (bus.wr && bus.addr == OFF_CTRL) begin
            n.pll_dis = bus.wdata[CTRL_PLL_DIS]; // R2
            n.single_channel_double_frequency = bus.wdata[CTRL_SINGLE_CHANNEL_DOUBLE_FREQUENCY]; // R21
            n.side = bus.wdata[CTRL_SIDE]; // R21
        end

        if (s.pll_dis) begin
            // recovery frozen and idle
            n.lock = 1'b0; // R2
            n.good = '0;
            n.unit = '1;
            n.iv = '0;
            n.ph = '0;
            n.in_pre = 1'b0;
            n.nbit = SUB_BITS;
            n.half = 1'b0;
            n.ser = '0;
        end else begin
            // R3
            if (edge_seen) begin
                n.iv = {{(IV_W-1){1'b0}}, 1'b1};
            end else if (s.iv != '1) begin
                n.iv = s.iv + 1'b1;
            end
            if (edge_seen) begin
                if (!s.lock && shorter) begin
                    n.unit = s.iv; // R8
                    n.good = '0;
                end else if (k == 2'h1) begin
                    n.unit = trk_sum[IV_W+1:2]; // R9
                end
                if (k == 2'h0) begin
                    n.bip_err = n.bip_err | s.lock;
                    n.lock = 1'b0;
                    n.good = '0;
                    n.unit = '1;
                    n.in_pre = 1'b0;
                    n.nbit = SUB_BITS;
                end else if (s.in_pre) begin
                    if (s.pre_first) begin
                        n.pre_first = 1'b0;
                        n.chan_b = (k == 2'h2);
                        n.blk = (k == 2'h1);
                    end
                    n.pre_sum = s.pre_sum + {2'b00, k};
                    if (n.pre_sum >= PRE_HALFCELLS) begin
                        n.in_pre = 1'b0;
                        n.nbit = '0;
                        if (!n.chan_b) begin
                            n.frame = n.blk ? 8'h00 : s.frame + 8'h01;
                            if (s.burst_on) begin
                                n.bcnt = s.bcnt + 13'h0001;
                                if (s.bcnt == 13'(BURST_FRAMES - 1)) begin
                                    n.burst_on = 1'b0; // R14
                                    n.pre_c = '0; // R17
                                    n.pre_d = '0; // R17
                                end
                            end
                        end
                    end
                end else if (k == 2'h3) begin
                    n.in_pre = 1'b1;
                    n.pre_first = 1'b1;
                    n.pre_sum = PRE_FIRST_SUM;
                    n.half = 1'b0;
                    n.sf_bad = 1'b0;
                    bad = (s.nbit != SUB_BITS);
                end else if (s.nbit != SUB_BITS) begin
                    if (k == 2'h2) begin
                        got = 1'b1;
                        bad = s.half;
                        n.half = 1'b0;
                    end else if (s.half) begin
                        got = 1'b1;
                        bitv = 1'b1;
                        n.half = 1'b0;
                    end else begin
                        n.half = 1'b1;
                    end
                end
            end else if (stall && s.unit != '1) begin
                // input silent: drop lock and start over
                n.nostream = 1'b1;
                n.lock = 1'b0;
                n.unit = '1;
                n.good = '0;
                n.in_pre = 1'b0;
                n.nbit = SUB_BITS;
            end
            if (bad) begin
                n.bip_err = n.bip_err | s.lock;
                n.sf_bad = 1'b1;
            end
            if (got) begin
                nsr = {bitv, s.sr[27:1]};
                n.sr = nsr;
                n.nbit = s.nbit + 5'h01;
                done = (s.nbit == LAST_BIT);
            end

            if (done) begin
                sf_bad_now = s.sf_bad | bad | (^nsr);
                w16 = nsr[23:8];
                if (^nsr) begin
                    n.par_err = 1'b1;
                end
                if (sf_bad_now) begin
                    n.good = '0;
                end else if (s.good != 3'(GOOD_N - 1)) begin
                    n.good = s.good + 3'h1;
                end
                if (!s.lock && !sf_bad_now && s.good == 3'(GOOD_N - 1)) begin
                    n.lock = 1'b1; // R4
                    n.lock_unit = s.unit;
                    n.irq[IRQ_LOCK] = 1'b1; // R5
                end
                if (nsr[V_POS]) begin
                    n.valid_st = 1'b1; // R12
                    n.irq[IRQ_VALID] = 1'b1;
                end
                if (!s.chan_b && s.frame < CS_FRAMES) begin
                    n.cs_sh = {nsr[C_POS], s.cs_sh[15:1]};
                    if (s.frame == CS_LAST) begin
                        n.byte0 = n.cs_sh[7:0];
                        n.byte1 = n.cs_sh[15:8];
                    end
                end
                n.osh = {nsr[23:0], 8'h00}; // R7
                n.ser.fs = s.single_channel_double_frequency ? s.side : s.chan_b; // R21
                // scan every word regardless of validity or byte 0
                case (s.bst) // R16
                    BS_ZERO: begin
                        if (nsr[23:0] == '0) begin
                            if (s.zc != ZERO_WORDS) begin
                                n.zc = s.zc + 3'h1;
                            end
                        end else if (s.zc == ZERO_WORDS && w16 == SYNC_PA) begin
                            n.bst = BS_PB; // R13
                            n.zc = '0;
                        end else begin
                            n.zc = '0;
                        end
                    end
                    BS_PB: begin
                        if (w16 == SYNC_PB) begin
                            n.bst = BS_CAP_C;
                            n.burst_on = 1'b1; // R13
                            n.bcnt = '0;
                        end else begin
                            n.bst = BS_ZERO;
                        end
                    end
                    BS_CAP_C: begin
                        n.pre_c = w16; // R15
                        n.bst = BS_CAP_D;
                    end
                    BS_CAP_D: begin
                        n.pre_d = w16; // R15
                        n.bst = BS_ZERO;
                    end
                    default: n.bst = BS_ZERO;
                endcase
            end

            if (drift_bad) begin
                n.lock = 1'b0;
                n.good = '0;
            end

            // recovered timing: one tick per half-cell, resynced on edges
            if (s.lock) begin
                if (edge_seen || s.ph == s.unit - 1'b1) begin
                    n.ph = '0;
                    tick = 1'b1;
                end else begin
                    n.ph = s.ph + 1'b1;
                end
                if (tick) begin
                    n.ser.hf = ~s.ser.hf; // R7
                    n.ser.sclk = ~s.ser.sclk;
                    if (s.ser.sclk && !done) begin
                        n.ser.dat = s.osh[31]; // R6
                        n.osh = {s.osh[30:0], 1'b0};
                    end
                end else if (s.unit > {{(IV_W-1){1'b0}}, 1'b1} && s.ph == (s.unit >> 1)) begin
                    n.ser.hf = ~s.ser.hf;
                end
            end else begin
                n.ph = '0;
                n.ser.sclk = 1'b0; // R6
                n.ser.dat = 1'b0;
                n.ser.hf = 1'b0;
            end
        end

        n.nonpcm = s.byte0[1] | s.burst_on; // R10 R13
        if (n.nonpcm && !s.nonpcm) begin
            n.irq[IRQ_NONPCM] = 1'b1; // R11
        end
        if (s.byte0[0]) begin
            n.emph = (pro_e == PRO_EMPH_A) || (pro_e == PRO_EMPH_B); // R18
        end else begin
            n.emph = (con_e == CON_EMPH_A) || (con_e == CON_EMPH_B) || (con_e == CON_EMPH_C); // R19
        end
        if (n.emph && !s.emph) begin
            n.irq[IRQ_EMPH] = 1'b1; // R20
        end
        case (b1_code) // R22
            SINGLE_CHANNEL_DOUBLE_FREQUENCY_CODE: n.single_channel_double_frequency_kind = KIND_SINGLE_CHANNEL_DOUBLE_FREQUENCY;
            SINGLE_CHANNEL_DOUBLE_FREQUENCY_LEFT_CODE: n.single_channel_double_frequency_kind = KIND_LEFT;
            SINGLE_CHANNEL_DOUBLE_FREQUENCY_RIGHT_CODE: n.single_channel_double_frequency_kind = KIND_RIGHT;
            default: n.single_channel_double_frequency_kind = KIND_NONE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            s <= '0;
            s.unit <= '1;
            s.nbit <= SUB_BITS;
            s.bst <= BS_ZERO;
            s.pll_dis <= CTRL_PLL_DIS_RST; // R1
        end else begin
            s <= n;
        end
    end

    assign rdata = s.rdata;
    assign ser = s.ser;
    assign audio_irq_latch = s.irq;
endmodule : spdr_receiver

// ==== spdr_pkg.sv ====
package spdr_pkg;
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_STAT = 4'h4;
    localparam logic [3:0] OFF_CHAN = 4'h8;
    localparam logic [3:0] OFF_PRE = 4'hC;
    localparam int CTRL_SINGLE_CHANNEL_DOUBLE_FREQUENCY = 0;
    localparam int CTRL_SIDE = 1;
    localparam int CTRL_PLL_DIS = 7;
    localparam logic CTRL_PLL_DIS_RST = 1'b0;
    localparam int ST_NONPCM = 0;
    localparam int ST_EMPH = 1;
    localparam int ST_NOSTREAM = 2;
    localparam int ST_VALID = 3;
    localparam int ST_LOCK = 4;
    localparam int ST_PARITY = 6;
    localparam int ST_BIPHASE = 7;
    localparam int ST_SINGLE_CHANNEL_DOUBLE_FREQUENCY_KIND = 8;
    localparam int ST_BYTE0 = 16;
    localparam logic [3:0] PRE_HALFCELLS = 4'h8;
    localparam logic [3:0] PRE_FIRST_SUM = 4'h3;
    localparam logic [4:0] SUB_BITS = 5'h1C;
    localparam logic [4:0] LAST_BIT = 5'h1B;
    localparam int V_POS = 24;
    localparam int C_POS = 26;
    localparam logic [7:0] CS_FRAMES = 8'h10;
    localparam logic [7:0] CS_LAST = 8'h0F;
    localparam logic [2:0] ZERO_WORDS = 3'h4;
    localparam logic [15:0] SYNC_PA = 16'hF872;
    localparam logic [15:0] SYNC_PB = 16'h4E1F;
    localparam int PCT_BASE = 100;
    localparam int DRIFT_PCT = 15;
    localparam int BURST_FRAMES_DEF = 4096;
    localparam int GOOD_SUBFRAMES_DEF = 4;
    localparam logic [2:0] PRO_EMPH_A = 3'h6;
    localparam logic [2:0] PRO_EMPH_B = 3'h7;
    localparam logic [2:0] CON_EMPH_A = 3'h4;
    localparam logic [2:0] CON_EMPH_B = 3'h2;
    localparam logic [2:0] CON_EMPH_C = 3'h6;
    localparam logic [3:0] SINGLE_CHANNEL_DOUBLE_FREQUENCY_CODE = 4'h7;
    localparam logic [3:0] SINGLE_CHANNEL_DOUBLE_FREQUENCY_LEFT_CODE = 4'h8;
    localparam logic [3:0] SINGLE_CHANNEL_DOUBLE_FREQUENCY_RIGHT_CODE = 4'h9;
    localparam logic [1:0] KIND_NONE = 2'h0;
    localparam logic [1:0] KIND_SINGLE_CHANNEL_DOUBLE_FREQUENCY = 2'h1;
    localparam logic [1:0] KIND_LEFT = 2'h2;
    localparam logic [1:0] KIND_RIGHT = 2'h3;
    localparam int IRQ_LOCK = 0;
    localparam int IRQ_NONPCM = 1;
    localparam int IRQ_EMPH = 2;
    localparam int IRQ_VALID = 3;
    localparam int IRQ_W = 4;

    typedef enum logic [1:0] {BS_ZERO, BS_PB, BS_CAP_C, BS_CAP_D} spdr_burst_e;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } spdr_bus_s;

    typedef struct packed {
        logic sclk;
        logic fs;
        logic dat;
        logic hf;
    } spdr_ser_s;
endpackage : spdr_pkg

// ==== spdr_src.sv ====
`timescale 1ns/1ps
module spdr_src
    import spdr_pkg::*;
#(
    parameter int T = 4
) (
    input wire logic clock,
    output logic line
);
    logic [15:0] cs = 16'h0000;
    logic v = 1'b0;
    logic [23:0] q[$];
    event blk_done;
    int pre[3][3] = '{'{1, 1, 3}, '{3, 1, 1}, '{2, 1, 2}};

    initial line = 1'b0;

    // one interval of n half-cells, closed by a transition
    task automatic iv(input int n);
        repeat (n * T) @(posedge clock);
        line <= ~line;
    endtask : iv

    // fields picked after the preamble so late updates still land
    task automatic sub(input int p, input int f);
        logic [27:0] s;
        iv(3);
        for (int k = 0; k < 3; k++) begin
            iv(pre[p][k]);
        end
        s[23:0] = (q.size() > 0) ? q.pop_front() : 24'hA5C3F0;
        s[27:24] = {1'b0, cs[f], 1'b0, v};
        s[27] = ^s[26:0];
        for (int i = 0; i < 28; i++) begin
            if (s[i]) begin
                iv(1);
                iv(1);
            end else begin
                iv(2);
            end
        end
    endtask : sub

    initial begin
        forever begin
            for (int f = 0; f < 16; f++) begin
                sub((f == 0) ? 0 : 1, f);
                sub(2, f);
            end
            -> blk_done;
        end
    end
endmodule : spdr_src

// ==== spdr_receiver_checker.sv ====
`timescale 1ns/1ps
module spdr_receiver_checker
    import spdr_pkg::*;
#(
    parameter int IV_W = 8,
    parameter int GOOD_N = GOOD_SUBFRAMES_DEF,
    parameter int BURST_FRAMES = BURST_FRAMES_DEF
) (
    input wire logic clock,
    input wire logic rstn,
    input wire spdr_bus_s bus,
    input wire logic [31:0] rdata,
    input wire logic biphase_in,
    input wire spdr_ser_s ser,
    input wire logic [IRQ_W-1:0] audio_irq_latch
);
    logic [7:0] ctl;
    logic v_pend;
    logic rd_stat;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    assign rd_stat = bus.rd && bus.addr == OFF_STAT;

    // shadow of control and of an unread validity event
    always_ff @(posedge clock) begin
        if (!rstn) begin
            ctl <= 8'h00;
            v_pend <= 1'b0;
        end else begin
            if (bus.wr && bus.addr == OFF_CTRL) begin
                ctl <= bus.wdata[7:0];
            end
            v_pend <= (v_pend || audio_irq_latch[IRQ_VALID]) && !rd_stat;
        end
    end

    sequence s_pll_off_wr;
        bus.wr && bus.addr == OFF_CTRL && bus.wdata[CTRL_PLL_DIS];
    endsequence
    sequence s_stat_rd;
        bus.rd && bus.addr == OFF_STAT;
    endsequence

    property p_ctrl_back;
        bus.rd && bus.addr == OFF_CTRL |=> rdata == {24'h000000, ctl[7], 5'h00, ctl[1:0]};
    endproperty
    property p_pll_off_ser;
        s_pll_off_wr |=> ##1 (ser == 4'h0) [*8];
    endproperty
    property p_pll_off_rd;
        s_stat_rd ##0 $past(ctl[CTRL_PLL_DIS]) |=> !rdata[ST_LOCK];
    endproperty
    property p_off_nolock;
        ctl[CTRL_PLL_DIS] && $past(ctl[CTRL_PLL_DIS]) |-> !audio_irq_latch[IRQ_LOCK];
    endproperty
    property p_lock_from_idle;
        $rose(audio_irq_latch[IRQ_LOCK]) |-> $past({ser.sclk, ser.dat, ser.hf}) == 3'h0;
    endproperty
    property p_hf_runs;
        audio_irq_latch[IRQ_LOCK] |-> ##[1:32] $changed(ser.hf);
    endproperty
    property p_lock_pulse;
        audio_irq_latch[IRQ_LOCK] |=> !audio_irq_latch[IRQ_LOCK];
    endproperty
    property p_nonpcm_pulse;
        audio_irq_latch[IRQ_NONPCM] |=> !audio_irq_latch[IRQ_NONPCM];
    endproperty
    property p_emph_pulse;
        audio_irq_latch[IRQ_EMPH] |=> !audio_irq_latch[IRQ_EMPH];
    endproperty
    property p_valid_sticky;
        s_stat_rd ##0 v_pend |=> rdata[ST_VALID];
    endproperty

    a_ctrl_back: assert property (p_ctrl_back)
        else $error("control readback differs");
    a_pll_off_ser: assert property (p_pll_off_ser)
        else $error("serial outputs run with recovery off");
    a_pll_off_rd: assert property (p_pll_off_rd)
        else $error("lock reads set with recovery off");
    a_off_nolock: assert property (p_off_nolock)
        else $error("lock event with recovery off");
    a_lock_from_idle: assert property (p_lock_from_idle)
        else $error("serial outputs active before lock");
    a_hf_runs: assert property (p_hf_runs)
        else $error("fast clock idle after lock");
    a_lock_pulse: assert property (p_lock_pulse)
        else $error("lock event longer than one cycle");
    a_nonpcm_pulse: assert property (p_nonpcm_pulse)
        else $error("non-audio event longer than one cycle");
    a_emph_pulse: assert property (p_emph_pulse)
        else $error("emphasis event longer than one cycle");
    a_valid_sticky: assert property (p_valid_sticky)
        else $error("validity status lost before read");
endmodule : spdr_receiver_checker

bind spdr_receiver spdr_receiver_checker #(
    .IV_W(IV_W),
    .GOOD_N(GOOD_N),
    .BURST_FRAMES(BURST_FRAMES)
) u_chk (
    .clock(clock), .rstn(rstn), .bus(bus), .rdata(rdata), .biphase_in(biphase_in),
    .ser(ser), .audio_irq_latch(audio_irq_latch)
);

// ==== tb.sv ====
`timescale 1ns/1ps
module tb
    import spdr_pkg::*;
();
    typedef struct packed {
        logic [7:0] b0;
        logic [7:0] b1;
        logic [1:0] kd;
        logic em;
        logic np;
    } spdr_row_s;

    logic clock = 1'b0;
    logic rstn = 1'b0;
    spdr_bus_s bus = '0;
    logic [31:0] rdata;
    logic line;
    spdr_ser_s ser;
    logic [IRQ_W-1:0] irq;
    int num_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [31:0] rv;
    logic [31:0] sreg = 32'h0;
    logic seen = 1'b0;
    logic clr = 1'b0;
    spdr_row_s rows[6] = '{
        '{8'h0F, 8'h0E, KIND_SINGLE_CHANNEL_DOUBLE_FREQUENCY, 1'b1, 1'b1},
        '{8'h1D, 8'h01, KIND_LEFT, 1'b1, 1'b0},
        '{8'h08, 8'h09, KIND_RIGHT, 1'b1, 1'b0},
        '{8'h10, 8'h00, KIND_NONE, 1'b1, 1'b0},
        '{8'h18, 8'h00, KIND_NONE, 1'b1, 1'b0},
        '{8'h05, 8'h0F, KIND_NONE, 1'b0, 1'b0}
    };

    spdr_receiver #(.IV_W(8), .GOOD_N(4), .BURST_FRAMES(8)) dut (
        .clock(clock), .rstn(rstn), .bus(bus), .rdata(rdata), .biphase_in(line),
        .ser(ser), .audio_irq_latch(irq)
    );
    spdr_src #(.T(4)) src (.clock(clock), .line(line));

    initial forever #50 clock = ~clock;

    // serial word assembled on the recovered clock
    always @(posedge ser.sclk) sreg <= {sreg[30:0], ser.dat};
    always @(posedge clock) seen <= !clr && (seen || (ser.sclk && sreg == 32'hA5C3F000));

    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            num_errors++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clock);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clock);
        bus.rd <= 1'b0;
        @(negedge clock);
        d = rdata;
        @(posedge clock);
    endtask : rd

    task automatic wait_irq(input int b, input int lim);
        int k;
        k = 0;
        while (irq[b] !== 1'b1 && k < lim) begin
            @(negedge clock);
            k++;
        end
        chk(irq[b], 1'b1);
        @(posedge clock);
    endtask : wait_irq

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        repeat (2) @(posedge clock);
        // no setup write: the receiver must lock by itself
        wait_irq(IRQ_LOCK, 20000);
        rd(OFF_STAT, rv);
        chk(rv[ST_LOCK], 1'b1);
        $display("done: lock");
        wr(OFF_CTRL, 32'hFFFFFFFF);
        clr <= 1'b1;
        @(posedge clock);
        clr <= 1'b0;
        rd(OFF_CTRL, rv);
        chk(rv, 32'h00000083);
        rd(OFF_STAT, rv);
        chk(rv[ST_LOCK], 1'b0);
        rd(4'h2, rv);
        chk(rv, 32'h00000000);
        repeat (600) @(posedge clock);
        chk(seen, 1'b0);
        wr(OFF_CTRL, 32'h00000000);
        wait_irq(IRQ_LOCK, 4000);
        repeat (1000) @(posedge clock);
        chk(seen, 1'b1);
        $display("done: pll control");
        @(src.blk_done);
        foreach (rows[i]) begin
            src.cs = {rows[i].b1, rows[i].b0};
            @(src.blk_done);
            @(posedge clock);
            rd(OFF_STAT, rv);
            chk({rv[23:16], rv[9:8], rv[1:0]}, {rows[i].b0, rows[i].kd, rows[i].em, rows[i].np});
            rd(OFF_CHAN, rv);
            chk(rv[7:0], rows[i].b1);
            $display("done: row %0d", i);
        end
        src.v = 1'b1;
        src.q = '{24'h0, 24'h0, 24'h0, 24'h0, 24'hF87200, 24'h4E1F00, 24'h5A3C00, 24'h123400};
        repeat (3000) @(posedge clock);
        src.v = 1'b0;
        repeat (600) @(posedge clock);
        rd(OFF_STAT, rv);
        chk({rv[ST_VALID], rv[ST_NONPCM]}, 2'h3);
        rd(OFF_STAT, rv);
        chk(rv[ST_VALID], 1'b0);
        rd(OFF_PRE, rv);
        chk(rv, 32'h12345A3C);
        repeat (6000) @(posedge clock);
        rd(OFF_STAT, rv);
        chk(rv[ST_NONPCM], 1'b0);
        rd(OFF_PRE, rv);
        chk(rv, 32'h00000000);
        $display("done: burst");
        wr(OFF_CTRL, 32'h00000003);
        repeat (600) @(posedge clock);
        @(negedge clock);
        chk(ser.fs, 1'b1);
        $display("done: double frequency");
        report_and_stop();
    end
endmodule : tb
